// file: pkg/lsd_pkg.sv
// Shared constants for the LED sink shift-and-latch front end.
// Assumes a single pclk domain; all pins enter through the pin synchroniser.
package lsd_pkg;
  // Channel count, which is also the serial chain length, and APB address and data widths.
  localparam int CH_N = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Bit positions inside the synchronised pin vector.
  localparam int PIN_SHORT = 0;
  localparam int PIN_OPEN = CH_N;
  localparam int PIN_TEMP = 2 * CH_N;
  localparam int PIN_OEN = PIN_TEMP + 1;
  localparam int PIN_LD = PIN_TEMP + 2;
  localparam int PIN_SIN = PIN_TEMP + 3;
  localparam int PIN_SCLK = PIN_TEMP + 4;
  localparam int PIN_W = PIN_TEMP + 5;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIAG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;

  // Control fields.
  localparam int CTRL_ERR_EN = 0;
  localparam int CTRL_LOW_CUR = 1;
  localparam int CTRL_W = 2;

  // Status fields: data register, global fault, temperature, mode code.
  localparam int ST_DATA = 0;
  localparam int ST_GFAULT = 8;
  localparam int ST_TEMP = 9;
  localparam int ST_MODE = 12;
  localparam int MODE_W = 3;

  // Diagnostic result fields.
  localparam int DG_OPEN = 0;
  localparam int DG_SHORT = 8;

  // Interrupt status bits.
  localparam int IRQ_LOAD = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_MODE = 2;
  localparam int IRQ_W = 3;

  // Operating modes: normal shifting, then the error modes in stepping order.
  typedef enum logic [MODE_W-1:0] {
    MODE_NORMAL,
    MODE_GLOBAL,
    MODE_OPEN,
    MODE_SHORT,
    MODE_TEMP
  } lsd_mode_t;
endpackage

// file: design/lsd_pin_sync.sv
// Three-stage synchroniser for asynchronous pins with edge pulses.
// Assumes pins may change at any time relative to pclk.
`timescale 1ns/10ps
module lsd_pin_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, level_ff, rise_ff, fall_ff;
  logic [W-1:0] nxt_level, agree;

  // A bit only changes once stages two and three agree, which rejects a single late sample.
  always_comb begin
    agree = ~(s2_ff ^ s3_ff);
    nxt_level = (agree & s3_ff) | (~agree & level_ff);
  end

  // Stage one feeds stage two and nothing else.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
    end else if (ce) begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
      rise_ff <= nxt_level & ~level_ff;
      fall_ff <= ~nxt_level & level_ff;
    end
  end

  assign level = level_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule // lsd_pin_sync

// file: design/lsd_shift_chain.sv
// Serial shift register with a rise-side hold stage and a fall-side output stage.
// Assumes one-cycle rise and fall pulses of the serial clock from the synchroniser.
`timescale 1ns/10ps
module lsd_shift_chain #(
  parameter int N = lsd_pkg::CH_N
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic shift_en,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic data_in,
  output logic [N-1:0] parallel,
  output logic chain_out
);
  logic [N-1:0] sr_ff, nxt_sr;
  logic hold_ff, nxt_hold, out_ff, nxt_out;

  // The hold stage adds the ninth rise so the bit leaves half a cycle later at the fall.
  always_comb begin
    nxt_sr = sr_ff;
    nxt_hold = hold_ff;
    nxt_out = out_ff;
    if (shift_en && sclk_rise) begin
      nxt_sr = {sr_ff[N-2:0], data_in};
      nxt_hold = sr_ff[N-1];
    end
    if (sclk_fall) begin
      nxt_out = hold_ff;
    end
  end

  // Registered state of the chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_ff <= '0;
      hold_ff <= 1'b0;
      out_ff <= 1'b0;
    end else if (ce) begin
      sr_ff <= nxt_sr;
      hold_ff <= nxt_hold;
      out_ff <= nxt_out;
    end
  end

  assign parallel = sr_ff;
  assign chain_out = out_ff;
endmodule // lsd_shift_chain

// file: design/lsd_top.sv
// Top of the LED sink shift-and-latch front end with diagnostic read-back.
// Assumes an APB master on pclk and serial pins driven asynchronously by a host or upstream driver.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// How it works
// - Capture serial_in on serial clock rise
// - serial_out changes on serial clock fall
// - Bit reappears 8.5 serial cycles later
// - latch_strobe rise copies shift register
// - Data register drives channels until reload
// - output_enable_n gates sinks in all modes
// - Serial rise steps error mode, no shift
// - Global mode: serial_out low on fault
// - Error-mode load records global and per-channel faults
// - Channels become sense inputs in diagnostics
// - Low-current flag during diagnostic modes
module lsd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsd_pkg::ADDR_W-1:0] paddr,
  input wire logic [lsd_pkg::DATA_W-1:0] pwdata,
  output logic [lsd_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic output_enable_n,
  input wire logic over_temp,
  input wire logic [lsd_pkg::CH_N-1:0] open_sense,
  input wire logic [lsd_pkg::CH_N-1:0] short_sense,
  output logic serial_out,
  output logic [lsd_pkg::CH_N-1:0] sink_channels,
  output logic sense_active,
  output logic low_current,
  output logic irq
);
  import lsd_pkg::*;

  // Word decode shared by the read and write paths.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  // Only lit channels are judged, so a blank channel never reports a fault of its own.
  function automatic logic [CH_N-1:0] judged(input logic [CH_N-1:0] sense, input logic [CH_N-1:0] lit);
    judged = sense & lit;
  endfunction

  logic [PIN_W-1:0] pins, pin_lvl, pin_rise, pin_fall;
  logic [CH_N-1:0] shift_par;
  logic shift_out;

  // Every pin crosses into pclk through the same three-stage synchroniser.
  // The serial pins are sampled, not used as clocks, so each level of serial_clk must last at
  // least six pclk periods; the trade is one clock domain for a slower link than the pin allows.
  // The concatenation order must match the pin positions in the package.
  assign pins = {serial_clk, serial_in, latch_strobe, output_enable_n, over_temp, open_sense, short_sense};

  lsd_pin_sync #(.W(PIN_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(pins),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic sclk_rise, sclk_fall, ld_rise, oen_lvl, sin_lvl, temp_lvl;
  logic [CH_N-1:0] open_lvl, short_lvl;

  // Named views of the synchronised pins.
  // Rise and fall pulses last one pclk, so each serial edge is acted on exactly once.
  assign sclk_rise = pin_rise[PIN_SCLK];
  assign sclk_fall = pin_fall[PIN_SCLK];
  assign ld_rise = pin_rise[PIN_LD];
  assign oen_lvl = pin_lvl[PIN_OEN];
  assign sin_lvl = pin_lvl[PIN_SIN];
  assign temp_lvl = pin_lvl[PIN_TEMP];
  assign open_lvl = pin_lvl[PIN_OPEN +: CH_N];
  assign short_lvl = pin_lvl[PIN_SHORT +: CH_N];

  lsd_mode_t mode_ff, nxt_mode;
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask, events;
  logic [CH_N-1:0] data_ff, nxt_data, open_res_ff, nxt_open_res, short_res_ff, nxt_short_res;
  logic gfault_ff, nxt_gfault, temp_res_ff, nxt_temp_res;
  logic in_err, step_mode, nxt_irq;

  assign in_err = (mode_ff != MODE_NORMAL);
  assign step_mode = in_err && sclk_rise && ctrl_ff[CTRL_ERR_EN];

  // Plain shifting only happens in normal mode; error modes use the clock to step instead.
  lsd_shift_chain #(.N(CH_N)) u_chain (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .shift_en(!in_err),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .data_in(sin_lvl),
    .parallel(shift_par),
    .chain_out(shift_out)
  );

  // Mode sequencer: software opens error mode, serial rises walk through it, clearing returns home.
  always_comb begin
    nxt_mode = mode_ff;
    if (!ctrl_ff[CTRL_ERR_EN]) begin
      nxt_mode = MODE_NORMAL;
    end else if (!in_err) begin
      nxt_mode = MODE_GLOBAL;
    end else if (step_mode) begin
      // A corrupted code drops back to normal mode, which also releases the sense pins.
      unique case (mode_ff)
        MODE_GLOBAL: nxt_mode = MODE_OPEN;
        MODE_OPEN: nxt_mode = MODE_SHORT;
        MODE_SHORT: nxt_mode = MODE_TEMP;
        MODE_TEMP: nxt_mode = MODE_GLOBAL;
        default: nxt_mode = MODE_NORMAL;
      endcase
    end
  end

  // Mode register; a low ce holds it together with every other state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_NORMAL;
    end else if (ce) begin
      mode_ff <= nxt_mode;
    end
  end

  // Load path: the data register and the fault records update only on a strobe rise.
  always_comb begin
    nxt_data = data_ff;
    nxt_gfault = gfault_ff;
    nxt_open_res = open_res_ff;
    nxt_short_res = short_res_ff;
    nxt_temp_res = temp_res_ff;
    if (ld_rise) begin
      nxt_data = shift_par;
      if (in_err) begin
        // The sense pins are read as inputs here because the sinks are in a diagnostic mode.
        nxt_open_res = judged(open_lvl, shift_par);
        nxt_short_res = judged(short_lvl, shift_par);
        nxt_temp_res = temp_lvl;
        // The global flag is the OR of the recorded faults, so it never disagrees with the details.
        nxt_gfault = (|nxt_open_res) | (|nxt_short_res) | temp_lvl;
      end
    end
  end

  // Data register and fault records, held between strobe rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= '0;
      gfault_ff <= 1'b0;
      open_res_ff <= '0;
      short_res_ff <= '0;
      temp_res_ff <= 1'b0;
    end else if (ce) begin
      data_ff <= nxt_data;
      gfault_ff <= nxt_gfault;
      open_res_ff <= nxt_open_res;
      short_res_ff <= nxt_short_res;
      temp_res_ff <= nxt_temp_res;
    end
  end

  logic serial_out_ff, nxt_serial_out, sense_ff, nxt_sense, low_cur_ff, nxt_low_cur;
  logic [CH_N-1:0] sink_ff, nxt_sink;

  // Pin-facing outputs. The global fault flag bypasses the chain, so cascading stops there.
  always_comb begin
    nxt_serial_out = (mode_ff == MODE_GLOBAL) ? ~gfault_ff : shift_out;
    nxt_sink = oen_lvl ? '0 : data_ff;
    // Sense and low current follow the mode one cycle late, in step with the other pin outputs.
    nxt_sense = in_err;
    nxt_low_cur = in_err && ctrl_ff[CTRL_LOW_CUR];
  end

  // Pin registers; serial_out leaves reset at the no-fault level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_ff <= 1'b1;
      sink_ff <= '0;
      sense_ff <= 1'b0;
      low_cur_ff <= 1'b0;
    end else if (ce) begin
      serial_out_ff <= nxt_serial_out;
      sink_ff <= nxt_sink;
      sense_ff <= nxt_sense;
      low_cur_ff <= nxt_low_cur;
    end
  end

  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, mapped, wr_done;
  logic [DATA_W-1:0] prdata_ff, nxt_prdata, rd_word;

  // Read mux; unmapped words read zero and answer with an error.
  // Bits above each field read zero, so software may compare whole words.
  always_comb begin
    rd_word = '0;
    mapped = 1'b1;
    if (hit(paddr, OFF_CTRL)) begin
      rd_word[CTRL_W-1:0] = ctrl_ff;
    end else if (hit(paddr, OFF_STATUS)) begin
      rd_word[ST_DATA +: CH_N] = data_ff;
      rd_word[ST_GFAULT] = gfault_ff;
      rd_word[ST_TEMP] = temp_res_ff;
      rd_word[ST_MODE +: MODE_W] = mode_ff;
    end else if (hit(paddr, OFF_DIAG)) begin
      rd_word[DG_OPEN +: CH_N] = open_res_ff;
      rd_word[DG_SHORT +: CH_N] = short_res_ff;
    end else if (hit(paddr, OFF_IRQ_STAT)) begin
      rd_word[IRQ_W-1:0] = irq_stat_ff;
    end else if (hit(paddr, OFF_IRQ_MASK)) begin
      rd_word[IRQ_W-1:0] = irq_mask_ff;
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state: pready rises at the edge that ends the first access cycle, the transfer ends on the next edge.
  // A refused write never commits, because wr_done waits for a clean completion.
  always_comb begin
    nxt_pready = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    wr_done = psel && penable && pready_ff && pwrite && !pslverr_ff;
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !mapped;
      nxt_prdata = pwrite ? '0 : rd_word;
    end
  end

  // Bus answer registers; prdata keeps its last value after the transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // Control, mask and write-one-to-clear status; a new event beats a clear in the same cycle.
  // Writes land only at the completing edge, together with the master's sample of pready.
  always_comb begin
    events = '0;
    events[IRQ_LOAD] = ld_rise;
    events[IRQ_FAULT] = ld_rise && in_err && nxt_gfault;
    events[IRQ_MODE] = step_mode;
    nxt_ctrl = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    if (wr_done && hit(paddr, OFF_CTRL)) begin
      nxt_ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_done && hit(paddr, OFF_IRQ_MASK)) begin
      nxt_irq_mask = pwdata[IRQ_W-1:0];
    end
    if (wr_done && hit(paddr, OFF_IRQ_STAT)) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
    // The level output looks at next state, so it rises in the same cycle as its status bit.
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  // Control, interrupt registers and the interrupt output flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
      irq_mask_ff <= '0;
      irq_stat_ff <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      irq_mask_ff <= nxt_irq_mask;
      irq_stat_ff <= nxt_irq_stat;
      irq <= nxt_irq;
    end
  end

  // Outputs come straight from their flip-flops.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign serial_out = serial_out_ff;
  assign sink_channels = sink_ff;
  assign sense_active = sense_ff;
  assign low_current = low_cur_ff;
endmodule // lsd_top

// file: tb/lsd_top_props.sv
// Checker for the top ports of the LED sink shift-and-latch front end.
// Assumes one pclk domain and pins that move slower than the synchroniser; checks pause while ce is low.
`timescale 1ns/10ps
module lsd_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clk,
  input wire logic latch_strobe,
  input wire logic output_enable_n,
  input wire logic serial_out,
  input wire logic [lsd_pkg::CH_N-1:0] sink_channels,
  input wire logic sense_active,
  input wire logic low_current
);
  // All checks share the APB clock and are idle while reset is low or ce freezes the block.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  // Completion is a single-cycle pulse after exactly one wait state.
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");

  // Eight cycles of a high enable pin leave room for the synchroniser, so sinks must be off.
  property p_oen_gate; output_enable_n [*8] |-> sink_channels == '0; endproperty
  a_oen_gate: assert property (p_oen_gate) else $error("sinks on while disabled");
  property p_hold; (!latch_strobe && !output_enable_n) [*8] |-> $stable(sink_channels); endproperty
  a_hold: assert property (p_hold) else $error("sinks moved without load");
  property p_low_cur; low_current |-> sense_active; endproperty
  a_low_cur: assert property (p_low_cur) else $error("low current outside diagnostics");

  // Cascade data may only move once the serial clock has been low for a few cycles.
  property p_out_fall;
    $changed(serial_out) && !sense_active && !$past(sense_active) && !$past(sense_active, 2)
      |-> !$past(serial_clk, 3);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("serial_out moved off falling edge");
endmodule // lsd_top_props

// file: tb/lsd_host_model.sv
// Host controller model that drives the serial pins of the LED sink front end.
// Assumes its tasks are called from one process aligned to pclk.
`timescale 1ns/10ps
module lsd_host_model (
  input wire logic pclk,
  input wire logic serial_out,
  output logic serial_clk,
  output logic serial_in,
  output logic latch_strobe
);
  // The serial clock stands low between frames.
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
  end

  // Eight pclk high and eight low keep each serial clock level at 40 ns, an 80 ns period, inside the rated rate.
  task automatic pulse();
    @(posedge pclk);
    serial_clk <= 1'b1;
    repeat (8) @(posedge pclk);
    serial_clk <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // Shifts one byte msb first and collects the bit that leaves after each fall.
  task automatic xfer(input logic [7:0] d, output logic [7:0] so);
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      serial_in <= d[i];
      repeat (8) @(posedge pclk);
      pulse();
      serial_in <= ~d[i]; // Held time is over, so the line no longer shows the bit.
      so[i] = serial_out;
    end
  endtask

  // Load strobe shared by every device of a chain, after eight bits each.
  task automatic load();
    @(posedge pclk);
    latch_strobe <= 1'b1;
    repeat (8) @(posedge pclk);
    latch_strobe <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule // lsd_host_model

// file: tb/lsd_top_bench.sv
// Self-checking bench for the LED sink front end: APB master plus host pin model.
// Assumes the package constants; APB waits are bounded, never counted in advance.
`timescale 1ns/10ps
module lsd_top_bench;
  import lsd_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic serial_clk, serial_in, latch_strobe, output_enable_n, over_temp, serial_out;
  logic [CH_N-1:0] open_sense, short_sense, sink_channels, so;
  logic sense_active, low_current, e;
  int miscompares = 0;
  int comparisons = 0;

  always #2.5 pclk = ~pclk;

  lsd_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(serial_clk), .serial_in(serial_in), .latch_strobe(latch_strobe),
    .output_enable_n(output_enable_n), .over_temp(over_temp), .open_sense(open_sense),
    .short_sense(short_sense), .serial_out(serial_out), .sink_channels(sink_channels),
    .sense_active(sense_active), .low_current(low_current), .irq(irq));
  lsd_host_model i_host (.pclk(pclk), .serial_out(serial_out), .serial_clk(serial_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe));

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n edges and stops mid-cycle, where registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // One APB transfer; a bounded wait guards against a missing pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    cyc(6);
    chk(32'(serial_out), 32'h0000_0000);
    chk(32'(sink_channels), 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk(32'(e), 32'h0000_0001);
  endtask

  // Byte in, load, then enable gating off and back on.
  task automatic t_shift_load();
    i_host.xfer(8'hA5, so);
    i_host.load();
    cyc(2);
    chk(32'(sink_channels), 32'h0000_00A5);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_00FF, 32'h0000_00A5);
    ce <= 1'b0;
    output_enable_n <= 1'b1;
    cyc(8);
    chk(32'(sink_channels), 32'h0000_00A5);
    @(posedge pclk);
    ce <= 1'b1;
    cyc(8);
    chk(32'(sink_channels), 32'h0000_0000);
    @(posedge pclk);
    output_enable_n <= 1'b0;
    cyc(8);
    chk(32'(sink_channels), 32'h0000_00A5);
    apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
    chk(r & 32'h0000_0001, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // The previous byte leaves on serial_out while the next one enters.
  task automatic t_cascade();
    i_host.xfer(8'h3C, so);
    chk(32'(so), 32'h0000_00A5);
  endtask

  // Diagnostic load, global fault on serial_out, interrupt and mode stepping.
  task automatic t_error();
    open_sense <= 8'h0F;
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    cyc(2);
    chk(32'({sense_active, low_current}), 32'h0000_0003);
    i_host.load();
    cyc(8);
    chk(32'(serial_out), 32'h0000_0000);
    apb(1'b0, OFF_DIAG, 32'h0000_0000);
    chk(r, 32'h0000_000C);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_7100, 32'h0000_1100);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
    cyc(1);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0007);
    cyc(1);
    chk(32'(irq), 32'h0000_0000);
    i_host.pulse();
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_70FF, 32'h0000_203C);
    chk(32'(irq), 32'h0000_0000);
    repeat (3) i_host.pulse();
    over_temp <= 1'b1;
    short_sense <= 8'h30;
    i_host.load();
    cyc(8);
    apb(1'b0, OFF_DIAG, 32'h0000_0000);
    chk(r, 32'h0000_300C);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_7300, 32'h0000_1300);
    chk(32'(irq), 32'h0000_0001);
    over_temp <= 1'b0;
    short_sense <= '0;
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    cyc(2);
    chk(32'(sense_active), 32'h0000_0000);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    output_enable_n = 1'b0;
    over_temp = 1'b0;
    open_sense = '0;
    short_sense = '0;
    repeat (8) @(posedge pclk);
    chk(32'(serial_out), 32'h0000_0001);
    presetn <= 1'b1;
    t_reset();
    t_shift_load();
    t_cascade();
    t_error();
    wrap_up();
  end
endmodule // lsd_top_bench

bind lsd_top lsd_top_props i_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk), .latch_strobe(latch_strobe),
  .output_enable_n(output_enable_n), .serial_out(serial_out), .sink_channels(sink_channels),
  .sense_active(sense_active), .low_current(low_current));
